/* shared/sfc_pkg.sv */
// Shared constants, register map and helper functions for the serial format block
package sfc_pkg;
	// ==========================================================
	// Clock and timing
	localparam int CLK_HZ          = 20_000_000;
	localparam int CLK_PERIOD_NS   = 50;
	localparam int TMO_UNIT_MS     = 10;
	localparam int TMO_UNIT_CYC    = TMO_UNIT_MS * 1_000_000 / CLK_PERIOD_NS;
	localparam int TMO_ZERO_MS     = 100;
	localparam logic [7:0] TMO_ZERO_UNITS = 8'(TMO_ZERO_MS / TMO_UNIT_MS);
	localparam int NCH             = 3;
	// ==========================================================
	// Register offsets inside a channel, channel stride 0x40
	localparam logic [5:0] OFS_FMT   = 6'h00;
	localparam logic [5:0] OFS_SREM  = 6'h04;
	localparam logic [5:0] OFS_RCNT  = 6'h08;
	localparam logic [5:0] OFS_PDISP = 6'h0c;
	localparam logic [5:0] OFS_TMO   = 6'h10;
	localparam logic [5:0] OFS_CTRL  = 6'h14;
	localparam logic [5:0] OFS_STAT  = 6'h18;
	localparam logic [5:0] OFS_HDR   = 6'h1c;
	localparam logic [5:0] OFS_TERM  = 6'h20;
	// ==========================================================
	// Reset values
	localparam logic [15:0] FMT_RST  = 16'h0000;
	localparam logic [15:0] TMO_RST  = 16'h0000;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	// ==========================================================
	// Format word fields
	localparam int FB_LEN8 = 0;
	localparam int FB_PAR  = 1;
	localparam int FB_STOP2 = 3;
	localparam int FB_BAUD = 4;
	localparam int FB_HDR  = 8;
	localparam int FB_TERM = 9;
	localparam int FB_CTL  = 10;
	localparam int FB_SUM  = 13;
	localparam int FB_PROTO = 14;
	localparam int FB_CRLF = 15;
	localparam logic [15:0] FMT_CTL_MASK = 16'h1c00;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ODD  = 2'h1;
	localparam logic [1:0] PAR_EVEN = 2'h3;
	localparam logic [2:0] CTL_NONE  = 3'h0;
	localparam logic [2:0] CTL_STD   = 3'h1;
	localparam logic [2:0] CTL_ILINK = 3'h2;
	localparam logic [2:0] CTL_MODEM = 3'h3;
	localparam logic [2:0] CTL_MULTI = 3'h7;
	localparam logic [2:0] CL_MULTI  = 3'h0;
	localparam logic [2:0] CL_P2P    = 3'h2;
	// Control and status fields
	localparam int CB_SLEN = 0;
	localparam int CB_RLEN = 8;
	localparam int CB_SEND = 16;
	localparam int CB_REARM = 17;
	localparam int SB_BUSY = 0;
	localparam int SB_WAIT = 1;
	localparam int SB_RXC  = 2;
	localparam int SB_TMO  = 3;
	localparam int SB_RERR = 4;
	localparam int SB_MULTI = 5;
	localparam logic [7:0] CHAR_CR = 8'h0d;
	localparam logic [7:0] CHAR_LF = 8'h0a;
	// ==========================================================
	// Bit rates and helpers
	localparam int BPS_DEF = 9600;
	function automatic logic [16:0] sfc_baud_div(input logic [3:0] code, input int hz);
		int bps;
		case (code)
			4'h3: bps = 300;
			4'h4: bps = 600;
			4'h5: bps = 1200;
			4'h6: bps = 2400;
			4'h7: bps = 4800;
			4'h8: bps = 9600;
			4'h9: bps = 19200;
			4'ha: bps = 38400;
			default: bps = BPS_DEF;
		endcase
		return 17'((hz + bps / 2) / bps);
	endfunction : sfc_baud_div
	function automatic logic [2:0] sfc_nbytes(input logic [31:0] w);
		logic [2:0] n;
		n = 3'h4;
		for (int i = 3; i >= 0; i--)
			if (w[8*i +: 8] == 8'h00)
				n = 3'(i);
		return n;
	endfunction : sfc_nbytes
	function automatic logic sfc_hit(input logic [7:0] a, input int ch, input logic [5:0] o);
		return (a[7:6] == 2'(ch)) && (a[5:0] == o);
	endfunction : sfc_hit
endpackage : sfc_pkg

/* hdl/sfc_tx.sv */
// Character serializer with selectable length, parity and stop bits
`timescale 1ns/10ps
module sfc_tx import sfc_pkg::*; (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [16:0] div,
	input  wire logic        len8,
	input  wire logic        par_en,
	input  wire logic        par_odd,
	input  wire logic        stop2,
	input  wire logic        start,
	input  wire logic [7:0]  data,
	output logic             busy,
	output logic             txd
);
	logic [16:0] cnt;
	logic [3:0]  nl;
	logic [3:0]  nd;
	logic [10:0] sh;
	logic [10:0] frm;
	logic [7:0]  dm;
	// ==========================================================
	// Frame builder
	always_comb
	begin
		nd = len8 ? 4'h8 : 4'h7;
		dm = len8 ? data : {1'b0, data[6:0]};
		frm = {3'h7, dm};
		if (!len8)
			frm[7] = 1'b1;
		frm[nd] = par_en ? ((^dm) ^ par_odd) : 1'b1;
	end
	// ==========================================================
	// Bit timing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy <= 1'b0;
			txd  <= 1'b1;
			cnt  <= 17'h0;
			nl   <= 4'h0;
			sh   <= 11'h7ff;
		end
		else if (!busy)
		begin
			if (start)
			begin
				busy <= 1'b1;
				txd  <= 1'b0;
				sh   <= frm;
				nl   <= nd + {3'h0, par_en} + (stop2 ? 4'h2 : 4'h1);
				cnt  <= 17'h0;
			end
		end
		else if (cnt != div - 17'h1)
			cnt <= cnt + 17'h1;
		else
		begin
			cnt <= 17'h0;
			if (nl == 4'h0)
			begin
				busy <= 1'b0;
				txd  <= 1'b1;
			end
			else
			begin
				txd <= sh[0];
				sh  <= {1'b1, sh[10:1]};
				nl  <= nl - 4'h1;
			end
		end
	end
endmodule : sfc_tx

/* hdl/sfc_rx.sv */
// Character deserializer with parity and stop bit check
`timescale 1ns/10ps
module sfc_rx import sfc_pkg::*; (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [16:0] div,
	input  wire logic        len8,
	input  wire logic        par_en,
	input  wire logic        par_odd,
	input  wire logic        rxd,
	output logic             valid,
	output logic [7:0]       data,
	output logic             err
);
	logic        act;
	logic [16:0] cnt;
	logic [3:0]  bn;
	logic [8:0]  sh;
	logic [3:0]  nd;
	logic [3:0]  ntot;
	logic [7:0]  dv;
	assign nd   = len8 ? 4'h8 : 4'h7;
	assign ntot = nd + {3'h0, par_en} + 4'h1;
	assign dv   = len8 ? sh[7:0] : {1'b0, sh[6:0]};
	// ==========================================================
	// Mid-bit sampling
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			act   <= 1'b0;
			cnt   <= 17'h0;
			bn    <= 4'h0;
			sh    <= 9'h0;
			valid <= 1'b0;
			data  <= 8'h00;
			err   <= 1'b0;
		end
		else
		begin
			valid <= 1'b0;
			if (!act)
			begin
				if (!rxd)
				begin
					act <= 1'b1;
					cnt <= {1'b0, div[16:1]};
					bn  <= 4'h0;
				end
			end
			else if (cnt != 17'h0)
				cnt <= cnt - 17'h1;
			else
			begin
				cnt <= div - 17'h1;
				bn  <= bn + 4'h1;
				if (bn == 4'h0 && rxd)
					act <= 1'b0;
				else if (bn == ntot)
				begin
					act   <= 1'b0;
					valid <= 1'b1;
					data  <= dv;
					err   <= !rxd || (par_en && (((^dv) ^ sh[nd]) != par_odd));
				end
				else if (bn != 4'h0)
					sh[bn - 4'h1] <= rxd;
			end
		end
	end
endmodule : sfc_rx

/* hdl/sfc_top.sv */
// Three-channel free-format serial port: format words, framing, counters, APB access
// Notes on behaviour
// - Format bits 2..1: 00 no parity, 01 odd, 11 even parity.
// - Format bits 7..4 codes 3 to 10 give 300 up to 38400 bit/s.
// - Bit 8 enables headers, bit 9 terminators; up to four bytes each.
// - Control code 000 none, 001 standard, 010 interlink, 011 modem handshake.
// - Control code 111 in free format selects the multidrop interface.
// - In link protocol mode code 000 is multidrop, code 010 point-to-point.
// - Bit 13 appends the sum byte after the terminators when sending.
// - Bit 15 set adds CR and LF to each message.
// - Channel zero without control lines is held at control code 111.
// - Keep the count of data bytes still to send in the frame.
// - Keep the count of data bytes received so far, one per byte.
// - After power-up a read-only copy holds the stored parameters.
// - Receive timeout counts in 10 ms steps, 1 to 255.
// - A timeout setting of zero acts as 100 ms.
// - Receive pause beyond timeout sets timeout flag and receive-complete flag.
// - Terminators are appended on send and end reception when matched.
// - Headers prefix sends and gate reception; zero first header byte disables.
`timescale 1ns/10ps
module sfc_top import sfc_pkg::*; #(
	parameter int CLK_HZ_P   = CLK_HZ,
	parameter int TMO_CYC_P  = TMO_UNIT_CYC,
	parameter bit CH0_NO_CTL = 1'b0
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [47:0] stored_params,
	input  wire logic [2:0]  rxd,
	input  wire logic [2:0]  dsr,
	output wire logic [2:0]  txd,
	output wire logic [2:0]  tx_de,
	output wire logic [2:0]  multidrop_sel,
	input  wire logic [23:0] tx_byte,
	input  wire logic [2:0]  tx_valid,
	output wire logic [2:0]  tx_ready,
	output wire logic [23:0] rx_byte,
	output wire logic [2:0]  rx_valid
);
	typedef enum logic [5:0] {
		TX_IDLE = 6'b000001,
		TX_HDR  = 6'b000010,
		TX_DATA = 6'b000100,
		TX_TERM = 6'b001000,
		TX_SUM  = 6'b010000,
		TX_CRLF = 6'b100000
	} sfc_tx_st_t;
	typedef enum logic [2:0] {
		RX_OFF  = 3'b001,
		RX_HDR  = 3'b010,
		RX_DATA = 3'b100
	} sfc_rx_st_t;
	localparam logic [17:0] TMO_LAST = 18'(TMO_CYC_P - 1);

	wire  [31:0] rd_w [NCH];
	logic        acc;
	logic        wr;
	logic        mapped;
	logic        loaded_r;
	// ==========================================================
	// APB slave: one wait state, read data latched at the edge raising pready, write at completing edge
	assign acc    = psel & penable & ~pready;
	assign wr     = psel & penable & pready & pwrite;
	assign mapped = (paddr[7:6] != 2'h3) && (paddr[5:0] <= OFS_TERM) && (paddr[1:0] == 2'h0);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= WORD_RST;
		end
		else if (acc)
		begin
			pready  <= 1'b1;
			pslverr <= !mapped;
			prdata  <= mapped ? rd_w[paddr[7:6]] : WORD_RST;
		end
		else
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end
	// Power-on load flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			loaded_r <= 1'b0;
		else
			loaded_r <= 1'b1;
	end
	// ==========================================================
	// Per-channel logic
	for (genvar c = 0; c < NCH; c++)
	begin : g_ch
		logic [15:0] fmt_r;
		logic [15:0] pdisp_r;
		logic [15:0] tmo_r;
		logic [31:0] hdr_r;
		logic [31:0] term_r;
		logic [7:0]  slen_r;
		logic [7:0]  rlen_r;
		logic [15:0] fmt_src;
		logic [15:0] fmt_fix;
		logic [2:0]  ctl;
		logic [2:0]  hn;
		logic [2:0]  tn;
		logic        proto;
		logic        multi;
		logic        hs;
		logic        hdr_on;
		logic        term_on;
		logic        sum_on;
		logic        crlf;
		logic        send_req;
		logic        rearm;
		logic [16:0] bdiv;
		sfc_tx_st_t  tst;
		logic [1:0]  tidx;
		logic [7:0]  rem_r;
		logic [7:0]  sum_r;
		logic        go_r;
		logic [7:0]  tb_r;
		logic        trdy_r;
		logic        ubusy;
		logic        can;
		logic        twait_r;
		logic        de_r;
		logic        multi_r;
		sfc_tx_st_t  nxt_d;
		sfc_tx_st_t  nxt_t;
		sfc_tx_st_t  nxt_s;
		sfc_rx_st_t  rst;
		logic [1:0]  ridx;
		logic [15:0] rcnt_r;
		logic        rxc_r;
		logic        tmof_r;
		logic        rerr_r;
		logic        got_r;
		logic [17:0] tcyc;
		logic [7:0]  tunit;
		logic [7:0]  tmo_lim;
		logic        tmo_ev;
		logic        term_last;
		logic        done_ev;
		logic        rvld_r;
		logic [7:0]  rbyte_r;
		logic        uv;
		logic [7:0]  ub;
		logic        uerr;
		logic [31:0] rd;
		// ==========================================================
		// Format decode
		assign ctl     = fmt_r[FB_CTL +: 3];
		assign proto   = fmt_r[FB_PROTO];
		assign multi   = proto ? (ctl == CL_MULTI) : (ctl == CTL_MULTI);
		assign hs      = !proto && (ctl == CTL_STD || ctl == CTL_ILINK || ctl == CTL_MODEM);
		assign hn      = sfc_nbytes(hdr_r);
		assign tn      = sfc_nbytes(term_r);
		assign hdr_on  = fmt_r[FB_HDR] && !proto && (hn != 3'h0);
		assign term_on = fmt_r[FB_TERM] && !proto && (tn != 3'h0);
		assign sum_on  = fmt_r[FB_SUM] && !proto;
		assign crlf    = fmt_r[FB_CRLF];
		assign bdiv    = sfc_baud_div(fmt_r[FB_BAUD +: 4], CLK_HZ_P);
		assign fmt_src = loaded_r ? pwdata[15:0] : stored_params[16*c +: 16];
		assign fmt_fix = (c == 0 && CH0_NO_CTL) ? (fmt_src | FMT_CTL_MASK) : fmt_src;
		assign send_req = wr && sfc_hit(paddr, c, OFS_CTRL) && pwdata[CB_SEND];
		assign rearm    = wr && sfc_hit(paddr, c, OFS_CTRL) && pwdata[CB_REARM];
		// ==========================================================
		// Configuration registers
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				fmt_r   <= FMT_RST;
				pdisp_r <= FMT_RST;
				tmo_r   <= TMO_RST;
				hdr_r   <= WORD_RST;
				term_r  <= WORD_RST;
				slen_r  <= 8'h00;
				rlen_r  <= 8'h00;
			end
			else
			begin
				if (!loaded_r)
					pdisp_r <= stored_params[16*c +: 16];
				if (!loaded_r || (wr && sfc_hit(paddr, c, OFS_FMT)))
					fmt_r <= fmt_fix;
				if (wr && sfc_hit(paddr, c, OFS_TMO))
					tmo_r <= pwdata[15:0];
				if (wr && sfc_hit(paddr, c, OFS_HDR))
					hdr_r <= pwdata;
				if (wr && sfc_hit(paddr, c, OFS_TERM))
					term_r <= pwdata;
				if (wr && sfc_hit(paddr, c, OFS_CTRL))
				begin
					slen_r <= pwdata[CB_SLEN +: 8];
					rlen_r <= pwdata[CB_RLEN +: 8];
				end
			end
		end
		// ==========================================================
		// Send sequencer: header, data, terminator, sum, CR LF
		assign can   = !ubusy && !go_r && !(hs && !dsr[c]);
		assign nxt_s = crlf ? TX_CRLF : TX_IDLE;
		assign nxt_t = sum_on ? TX_SUM : nxt_s;
		assign nxt_d = term_on ? TX_TERM : nxt_t;
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				tst    <= TX_IDLE;
				tidx   <= 2'h0;
				rem_r  <= 8'h00;
				sum_r  <= 8'h00;
				go_r   <= 1'b0;
				tb_r   <= 8'h00;
				trdy_r <= 1'b0;
			end
			else
			begin
				go_r <= 1'b0;
				case (tst)
					TX_IDLE:
						if (send_req)
						begin
							rem_r <= pwdata[CB_SLEN +: 8];
							sum_r <= 8'h00;
							tidx  <= 2'h0;
							tst   <= hdr_on ? TX_HDR : TX_DATA;
						end
					TX_HDR:
						if (can)
						begin
							go_r <= 1'b1;
							tb_r <= hdr_r[8*tidx +: 8];
							tidx <= ({1'b0, tidx} == hn - 3'h1) ? 2'h0 : tidx + 2'h1;
							if ({1'b0, tidx} == hn - 3'h1)
								tst <= TX_DATA;
						end
					TX_DATA:
						if (rem_r == 8'h00)
							tst <= nxt_d;
						else if (trdy_r && tx_valid[c])
						begin
							trdy_r <= 1'b0;
							go_r   <= 1'b1;
							tb_r   <= tx_byte[8*c +: 8];
							rem_r  <= rem_r - 8'h01;
							sum_r  <= sum_r + tx_byte[8*c +: 8];
						end
						else if (can)
							trdy_r <= 1'b1;
					TX_TERM:
						if (can)
						begin
							go_r <= 1'b1;
							tb_r <= term_r[8*tidx +: 8];
							tidx <= ({1'b0, tidx} == tn - 3'h1) ? 2'h0 : tidx + 2'h1;
							if ({1'b0, tidx} == tn - 3'h1)
								tst <= nxt_t;
						end
					TX_SUM:
						if (can)
						begin
							go_r <= 1'b1;
							tb_r <= sum_r;
							tst  <= nxt_s;
						end
					TX_CRLF:
						if (can)
						begin
							go_r <= 1'b1;
							tb_r <= (tidx == 2'h0) ? CHAR_CR : CHAR_LF;
							tidx <= (tidx == 2'h0) ? 2'h1 : 2'h0;
							if (tidx != 2'h0)
								tst <= TX_IDLE;
						end
					default:
						tst <= TX_IDLE;
				endcase
			end
		end
		// Line direction and status
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				twait_r <= 1'b0;
				de_r    <= 1'b0;
				multi_r <= 1'b0;
			end
			else
			begin
				twait_r <= (tst != TX_IDLE) && hs && !dsr[c];
				de_r    <= multi && (tst != TX_IDLE || ubusy || go_r);
				multi_r <= multi;
			end
		end
		sfc_tx u_tx (
			.pclk    (pclk),
			.presetn (presetn),
			.div     (bdiv),
			.len8    (fmt_r[FB_LEN8]),
			.par_en  (fmt_r[FB_PAR +: 2] != PAR_NONE),
			.par_odd (fmt_r[FB_PAR +: 2] == PAR_ODD),
			.stop2   (fmt_r[FB_STOP2]),
			.start   (go_r),
			.data    (tb_r),
			.busy    (ubusy),
			.txd     (txd[c])
		);
		sfc_rx u_rx (
			.pclk    (pclk),
			.presetn (presetn),
			.div     (bdiv),
			.len8    (fmt_r[FB_LEN8]),
			.par_en  (fmt_r[FB_PAR +: 2] != PAR_NONE),
			.par_odd (fmt_r[FB_PAR +: 2] == PAR_ODD),
			.rxd     (rxd[c]),
			.valid   (uv),
			.data    (ub),
			.err     (uerr)
		);
		// ==========================================================
		// Receive sequencer and timeout
		assign tmo_lim   = (tmo_r[7:0] == 8'h00) ? TMO_ZERO_UNITS : tmo_r[7:0];
		assign tmo_ev    = (rst != RX_OFF) && got_r && !uv && (tcyc == TMO_LAST)
			&& (tunit == tmo_lim - 8'h01);
		assign term_last = term_on && (ub == term_r[8*ridx +: 8]) && ({1'b0, ridx} == tn - 3'h1);
		assign done_ev   = ((rst == RX_DATA) && uv
			&& ((rcnt_r + 16'h1 == {8'h00, rlen_r}) || term_last)) || tmo_ev;
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				rst     <= RX_OFF;
				ridx    <= 2'h0;
				rcnt_r  <= 16'h0;
				rxc_r   <= 1'b0;
				tmof_r  <= 1'b0;
				rerr_r  <= 1'b0;
				got_r   <= 1'b0;
				tcyc    <= 18'h0;
				tunit   <= 8'h00;
				rvld_r  <= 1'b0;
				rbyte_r <= 8'h00;
			end
			else
			begin
				rvld_r <= 1'b0;
				if (rearm)
				begin
					rcnt_r <= 16'h0;
					tmof_r <= 1'b0;
					rerr_r <= 1'b0;
					rxc_r  <= 1'b0;
					got_r  <= 1'b0;
					ridx   <= 2'h0;
					tcyc   <= 18'h0;
					tunit  <= 8'h00;
					if (pwdata[CB_RLEN +: 8] == 8'h00)
						rst <= RX_OFF;
					else
						rst <= hdr_on ? RX_HDR : RX_DATA;
				end
				else if (rst != RX_OFF)
				begin
					if (uv)
					begin
						got_r <= 1'b1;
						tcyc  <= 18'h0;
						tunit <= 8'h00;
					end
					else if (got_r && tcyc == TMO_LAST)
					begin
						tcyc  <= 18'h0;
						tunit <= tunit + 8'h01;
					end
					else if (got_r)
						tcyc <= tcyc + 18'h1;
					if (uv && rst == RX_HDR)
					begin
						if (ub != hdr_r[8*ridx +: 8])
							ridx <= 2'h0;
						else if ({1'b0, ridx} == hn - 3'h1)
						begin
							ridx <= 2'h0;
							rst  <= RX_DATA;
						end
						else
							ridx <= ridx + 2'h1;
					end
					if (uv && rst == RX_DATA)
					begin
						rcnt_r  <= rcnt_r + 16'h1;
						rvld_r  <= 1'b1;
						rbyte_r <= ub;
						if (term_on && ub == term_r[8*ridx +: 8])
							ridx <= ridx + 2'h1;
						else
							ridx <= 2'h0;
					end
				end
				if (uv && uerr)
					rerr_r <= 1'b1;
				if (tmo_ev)
					tmof_r <= 1'b1;
				if (done_ev)
				begin
					rxc_r <= 1'b1;
					rst   <= RX_OFF;
				end
			end
		end
		// ==========================================================
		// Read data
		always_comb
		begin
			rd = WORD_RST;
			case (paddr[5:0])
				OFS_FMT:   rd[15:0] = fmt_r;
				OFS_SREM:  rd[7:0] = rem_r;
				OFS_RCNT:  rd[15:0] = rcnt_r;
				OFS_PDISP: rd[15:0] = pdisp_r;
				OFS_TMO:   rd[15:0] = tmo_r;
				OFS_CTRL:  rd[15:0] = {rlen_r, slen_r};
				OFS_STAT:
				begin
					rd[SB_BUSY]  = (tst != TX_IDLE) || ubusy;
					rd[SB_WAIT]  = twait_r;
					rd[SB_RXC]   = rxc_r;
					rd[SB_TMO]   = tmof_r;
					rd[SB_RERR]  = rerr_r;
					rd[SB_MULTI] = multi_r;
				end
				OFS_HDR:   rd = hdr_r;
				OFS_TERM:  rd = term_r;
				default:   rd = WORD_RST;
			endcase
		end
		assign rd_w[c]             = rd;
		assign tx_de[c]            = de_r;
		assign multidrop_sel[c]    = multi_r;
		assign tx_ready[c]         = trdy_r;
		assign rx_byte[8*c +: 8]   = rbyte_r;
		assign rx_valid[c]         = rvld_r;
	end
endmodule : sfc_top

/* verif/sfc_top_monitor.sv */
// Bus and framing checks for the serial format block
`timescale 1ns/10ps
module sfc_top_monitor (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic [2:0] txd,
	input wire logic [2:0] tx_de,
	input wire logic [2:0] multidrop_sel,
	input wire logic [2:0] tx_valid,
	input wire logic [2:0] tx_ready,
	input wire logic [2:0] rx_valid
);
	// ==========================================
	// Properties
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	sequence s_take;
		tx_valid[0] && tx_ready[0];
	endsequence
	a_ack_next: assert property (s_wait |=> pready)
		else $error("access not answered");
	a_ack_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	a_err_ack: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_no_chan3: assert property (pready && paddr[7:6] == 2'h3 |-> pslverr)
		else $error("missing pslverr");
	a_rx_pulse: assert property (rx_valid[0] |=> !rx_valid[0])
		else $error("rx_valid too long");
	a_take_drop: assert property (s_take |=> !tx_ready[0])
		else $error("tx_ready held after take");
	a_start_bit: assert property (s_take |-> ##[1:3] !txd[0])
		else $error("start bit late");
	a_de_multi: assert property ((tx_de & ~multidrop_sel) == 3'h0)
		else $error("driver enable outside multidrop");
endmodule : sfc_top_monitor
bind sfc_top sfc_top_monitor u_mon (.pclk, .presetn, .psel, .penable, .paddr, .pready,
	.pslverr, .txd, .tx_de, .multidrop_sel, .tx_valid, .tx_ready, .rx_valid);

/* verif/sfc_line_model.sv */
// Serial equipment on channel zero: frame capture and byte sender
`timescale 1ns/10ps
module sfc_line_model #(
	parameter int DIV = 10
) (
	input  wire logic pclk,
	input  wire logic txd,
	output logic      rxd
);
	logic [9:0] frame = 10'h000;
	int         nfr   = 0;
	initial rxd = 1'b1;
	// Samples ten bit centres after each start edge
	initial
	begin
		forever
		begin
			@(negedge txd);
			repeat (DIV / 2) @(posedge pclk);
			for (int i = 0; i < 10; i++)
			begin
				repeat (DIV) @(posedge pclk);
				frame[i] = txd;
			end
			nfr++;
		end
	end
	task send(input logic [7:0] b);
		logic [9:0] v;
		v = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge pclk);
			rxd <= v[i];
			repeat (DIV - 1) @(posedge pclk);
		end
	endtask : send
endmodule : sfc_line_model

/* verif/sfc_top_test.sv */
// Register, send and receive tests for the serial format block
`timescale 1ns/10ps
module sfc_top_test import sfc_pkg::*;;
	localparam logic [47:0] SP = 48'h9c86_1c81_0081;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, lrx;
	logic [23:0] tx_byte = 24'h0, rx_byte;
	logic [2:0]  tx_valid = 3'h0, txd, tx_de, msel, tx_ready, rx_valid;
	logic [2:0]  dsr = 3'h7;
	logic [15:0] mf [4] = '{16'h1c00, 16'h0400, 16'h4000, 16'h4800};
	int          bad_count = 0, cmp_count = 0, k;
	sfc_top #(.CLK_HZ_P(96000), .TMO_CYC_P(50)) u_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .stored_params(SP),
		.rxd({2'h3, lrx}), .dsr, .txd, .tx_de, .multidrop_sel(msel), .tx_byte,
		.tx_valid, .tx_ready, .rx_byte, .rx_valid);
	sfc_line_model #(.DIV(10)) u_line (.pclk, .txd(txd[0]), .rxd(lrx));
	initial
	begin
		forever #25 pclk = ~pclk;
	end
	// ==========================================
	// Bus and compare tasks
	task chk(input string n, input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			bad_count++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), rd, e);
	endtask : rc
	task snd(input logic [15:0] f, input logic [7:0] b);
		logic [9:0] v;
		int n;
		apb(1'b1, 8'h00, {16'h0, f});
		apb(1'b1, 8'h14, 32'h0001_0001);
		rc(8'h04, 32'h1);
		n = u_line.nfr;
		tx_byte[7:0] <= b;
		tx_valid[0] <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (tx_ready[0] !== 1'b1 && k < 100);
		tx_valid[0] <= 1'b0;
		chk("tx_de", {31'h0, tx_de[0]}, {31'h0, f[12:10] == CTL_MULTI});
		while (u_line.nfr == n && k < 400)
		begin
			@(posedge pclk);
			k++;
		end
		if (u_line.nfr == n)
			bad_count++;
		v = {2'h3, f[0] ? b : {1'b1, b[6:0]}};
		if (f[1])
			v[7 + f[0]] = ^(b & {f[0], 7'h7f}) ^ ~f[2];
		chk("frame", {22'h0, u_line.frame}, {22'h0, v});
		rc(8'h04, 32'h0);
	endtask : snd
	task rx_to(input logic [7:0] t, input int early, input int late);
		apb(1'b1, 8'h00, 32'h0081);
		apb(1'b1, 8'h10, {24'h0, t});
		apb(1'b1, 8'h14, 32'h0002_0500);
		u_line.send(8'h6e);
		u_line.send(8'hd2);
		chk("rx_byte", {24'h0, rx_byte[7:0]}, 32'hd2);
		repeat (early) @(posedge pclk);
		apb(1'b0, 8'h18, 32'h0);
		chk("status", rd & 32'hc, 32'h0);
		repeat (late) @(posedge pclk);
		apb(1'b0, 8'h18, 32'h0);
		chk("status", rd & 32'hc, 32'hc);
		rc(8'h08, 32'h2);
	endtask : rx_to
	task close_out;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	// ==========================================
	// Tests
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("msel", {29'h0, msel}, 32'h6);
		for (int i = 0; i < 3; i++)
		begin
			rc(8'(64 * i + 12), {16'h0, SP[16 * i +: 16]});
			rc(8'(64 * i), {16'h0, SP[16 * i +: 16]});
		end
		apb(1'b1, 8'h4c, 32'hffff);
		rc(8'h4c, 32'h1c81);
		apb(1'b1, 8'h40, 32'h0085);
		rc(8'h40, 32'h0085);
		rc(8'h80, 32'h9c86);
		apb(1'b0, 8'hc0, 32'h0);
		chk("slverr", {31'h0, er}, 32'h1);
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, 8'h80, {16'h0, mf[i]});
			repeat (3) @(posedge pclk);
			chk("msel2", {31'h0, msel[2]}, {31'h0, ~i[0]});
		end
		snd(16'h0081, 8'ha5);
		snd(16'h0086, 8'h3c);
		snd(16'h008a, 8'h5b);
		snd(16'h1c81, 8'h69);
		// Standard handshake: send stalls while the partner is not ready
		dsr[0] <= 1'b0;
		apb(1'b1, 8'h00, 32'h0481);
		apb(1'b1, 8'h14, 32'h0001_0001);
		rc(8'h18, 32'h3);
		dsr[0] <= 1'b1;
		snd(16'h0481, 8'h96);
		rx_to(8'h00, 400, 150);
		rx_to(8'h03, 100, 100);
		close_out();
	end
	initial
	begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		close_out();
	end
endmodule : sfc_top_test
